// *** hdl/i2crs_slave.sv ***
/*
 * Two-wire serial slave giving a bus master byte access to internal registers,
 * plus a data ready output. The serial engine runs on link_clk, which must be
 * several times faster than the serial clock; register strobes run on core_clk.
 * Assumes the register file answers reg_rd_data one core_clk after reg_rd_en.
 */
`timescale 1ns/10ps
`include "i2crs_consts.svh"

module i2crs_slave
	import i2crs_pkg::*;
(
	// Core clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Link sampling clock
	input  wire logic       link_clk,
	// Serial pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       address_select_pin,
	// Register file access
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic [7:0]      reg_addr,
	output logic [7:0]      reg_wdata,
	input  wire logic [7:0] reg_rd_data,
	// Sample set ready
	input  wire logic       sample_set_strobe,
	output logic            data_ready
);

	// ----------------------------------------------------------------
	// Link domain reset and pin synchronisers
	// ----------------------------------------------------------------
	logic link_rst_m_q;
	logic link_rst;
	logic scl_m_q;
	logic scl_s_q;
	logic scl_p_q;
	logic sda_m_q;
	logic sda_s_q;
	logic sda_p_q;
	logic sel_m_q;
	logic sel_s_q;

	always_ff @(posedge link_clk) begin
		link_rst_m_q <= rst;
		link_rst     <= link_rst_m_q;
	end

	// Released lines read high, so reset to one avoids a false START
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
			sel_m_q <= 1'b0;
			sel_s_q <= 1'b0;
		end else begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
			sel_m_q <= address_select_pin;
			sel_s_q <= sel_m_q;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [6:0] own_addr;

	assign scl_rise  = scl_s_q & ~scl_p_q;
	assign scl_fall  = ~scl_s_q & scl_p_q;
	assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign own_addr  = {`I2CRS_ADDR_HIGH, sel_s_q};

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	i2crs_state_t state_q;
	logic [2:0]   bit_cnt_q;
	logic         byte_full_q;
	logic [7:0]   shift_q;
	logic [7:0]   ptr_q;
	logic         dir_read_q;
	logic         mack_q;
	logic         req_vld_q;
	logic [16:0]  req_word_q;
	logic [7:0]   rdata_q;
	logic         addr_hit;

	assign addr_hit = shift_q[7:1] == own_addr;

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			state_q     <= ST_IDLE;
			bit_cnt_q   <= `I2CRS_BIT_FIRST;
			byte_full_q <= 1'b0;
			shift_q     <= `I2CRS_BYTE_ZERO;
			ptr_q       <= `I2CRS_PTR_RESET;
			dir_read_q  <= 1'b0;
			mack_q      <= 1'b0;
			sda_oe      <= 1'b0;
			req_vld_q   <= 1'b0;
			req_word_q  <= '0;
		end else begin
			req_vld_q <= 1'b0;
			if (start_det) begin
				// Repeated START restarts too
				state_q     <= ST_ADDR;
				bit_cnt_q   <= `I2CRS_BIT_FIRST;
				byte_full_q <= 1'b0;
				sda_oe      <= 1'b0;
			end else if (stop_det) begin
				state_q     <= ST_IDLE;
				byte_full_q <= 1'b0;
				sda_oe      <= 1'b0;
			end else begin
				unique case (state_q)
					ST_IDLE, ST_IGNORE: begin
						sda_oe <= 1'b0;
					end
					ST_ADDR, ST_REG, ST_WDATA: begin
						if (scl_rise) begin
							shift_q   <= {shift_q[6:0], sda_s_q};
							bit_cnt_q <= bit_cnt_q + 3'h1;
							if (bit_cnt_q == `I2CRS_BIT_LAST) begin
								byte_full_q <= 1'b1;
							end
						end else if (scl_fall && byte_full_q) begin
							byte_full_q <= 1'b0;
							bit_cnt_q   <= `I2CRS_BIT_FIRST;
							if (state_q == ST_ADDR) begin
								if (addr_hit) begin
									sda_oe     <= 1'b1;
									dir_read_q <= shift_q[0];
									state_q    <= ST_ADDR_ACK;
									if (shift_q[0] == `I2CRS_DIR_READ) begin
										// Prefetch so data is ready at ack end
										req_vld_q  <= 1'b1;
										req_word_q <= {1'b0, ptr_q, `I2CRS_BYTE_ZERO};
										ptr_q      <= ptr_q + `I2CRS_PTR_STEP;
									end
								end else begin
									state_q <= ST_IGNORE;
								end
							end else if (state_q == ST_REG) begin
								ptr_q   <= shift_q;
								sda_oe  <= 1'b1;
								state_q <= ST_REG_ACK;
							end else begin
								req_vld_q  <= 1'b1;
								req_word_q <= {1'b1, ptr_q, shift_q};
								ptr_q      <= ptr_q + `I2CRS_PTR_STEP;
								sda_oe     <= 1'b1;
								state_q    <= ST_WDATA_ACK;
							end
						end
					end
					ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
						if (scl_fall) begin
							bit_cnt_q <= `I2CRS_BIT_FIRST;
							if (state_q == ST_ADDR_ACK && dir_read_q) begin
								shift_q <= rdata_q;
								sda_oe  <= ~rdata_q[7];
								state_q <= ST_RDATA;
							end else begin
								sda_oe  <= 1'b0;
								state_q <= (state_q == ST_ADDR_ACK) ? ST_REG : ST_WDATA;
							end
						end
					end
					ST_RDATA: begin
						if (scl_rise) begin
							bit_cnt_q <= bit_cnt_q + 3'h1;
							if (bit_cnt_q == `I2CRS_BIT_LAST) begin
								byte_full_q <= 1'b1;
							end
						end else if (scl_fall) begin
							if (byte_full_q) begin
								byte_full_q <= 1'b0;
								sda_oe      <= 1'b0;
								state_q     <= ST_RDATA_ACK;
							end else begin
								shift_q <= {shift_q[6:0], 1'b0};
								sda_oe  <= ~shift_q[6];
							end
						end
					end
					ST_RDATA_ACK: begin
						if (scl_rise) begin
							mack_q <= ~sda_s_q;
							if (!sda_s_q) begin
								req_vld_q  <= 1'b1;
								req_word_q <= {1'b0, ptr_q, `I2CRS_BYTE_ZERO};
								ptr_q      <= ptr_q + `I2CRS_PTR_STEP;
							end
						end else if (scl_fall) begin
							bit_cnt_q <= `I2CRS_BIT_FIRST;
							if (mack_q) begin
								shift_q <= rdata_q;
								sda_oe  <= ~rdata_q[7];
								state_q <= ST_RDATA;
							end else begin
								state_q <= ST_IGNORE;
							end
						end
					end
					default: begin
						state_q <= ST_IDLE;
						sda_oe  <= 1'b0;
					end
				endcase
			end
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Crossings
	// ----------------------------------------------------------------
	logic        core_req_vld;
	logic [16:0] core_req_word;
	logic        rsp_vld_q;
	logic        link_rsp_vld;
	logic [7:0]  link_rsp_data;

	i2crs_xfer #(.W(17)) u_req_xfer (
		.src_clk   (link_clk),
		.src_rst   (link_rst),
		.src_valid (req_vld_q),
		.src_data  (req_word_q),
		.dst_clk   (core_clk),
		.dst_rst   (rst),
		.dst_valid (core_req_vld),
		.dst_data  (core_req_word)
	);

	i2crs_xfer #(.W(8)) u_rsp_xfer (
		.src_clk   (core_clk),
		.src_rst   (rst),
		.src_valid (rsp_vld_q),
		.src_data  (reg_rd_data),
		.dst_clk   (link_clk),
		.dst_rst   (link_rst),
		.dst_valid (link_rsp_vld),
		.dst_data  (link_rsp_data)
	);

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			rdata_q <= `I2CRS_BYTE_ZERO;
		end else if (link_rsp_vld) begin
			rdata_q <= link_rsp_data;
		end
	end

	// ----------------------------------------------------------------
	// Core side register strobes
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_wr_en <= 1'b0;
			reg_rd_en <= 1'b0;
			reg_addr  <= `I2CRS_PTR_RESET;
			reg_wdata <= `I2CRS_BYTE_ZERO;
			rsp_vld_q <= 1'b0;
		end else begin
			reg_wr_en <= core_req_vld & core_req_word[16];
			reg_rd_en <= core_req_vld & ~core_req_word[16];
			rsp_vld_q <= reg_rd_en;
			if (core_req_vld) begin
				reg_addr  <= core_req_word[15:8];
				reg_wdata <= core_req_word[7:0];
			end
		end
	end

	// Set wins over the clearing read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_ready <= 1'b0;
		end else if (sample_set_strobe) begin
			data_ready <= 1'b1;
		end else if (reg_rd_en && reg_addr == `I2CRS_SAMPLE_LAST) begin
			data_ready <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_addr_ack;
		@(posedge link_clk) disable iff (link_rst)
		(state_q == ST_ADDR && scl_fall && byte_full_q && addr_hit && !start_det && !stop_det)
			|=> (sda_oe && state_q == ST_ADDR_ACK);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("matched address not acked");

	property p_nomatch;
		@(posedge link_clk) disable iff (link_rst)
		state_q == ST_IGNORE |-> !sda_oe;
	endproperty
	a_nomatch: assert property (p_nomatch) else $error("data driven while not selected");

	property p_stop;
		@(posedge link_clk) disable iff (link_rst)
		stop_det && !start_det |=> (state_q == ST_IDLE && !sda_oe);
	endproperty
	a_stop: assert property (p_stop) else $error("stop not honoured");

	property p_start;
		@(posedge link_clk) disable iff (link_rst)
		start_det |=> (state_q == ST_ADDR && bit_cnt_q == `I2CRS_BIT_FIRST && !sda_oe);
	endproperty
	a_start: assert property (p_start) else $error("repeated start not taken");

	property p_msb_first;
		@(posedge link_clk) disable iff (link_rst)
		(state_q == ST_ADDR_ACK && dir_read_q && scl_fall && !start_det && !stop_det)
			|=> (state_q == ST_RDATA && sda_oe == !$past(rdata_q[7]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("first read bit not msb");

	property p_wr_inc;
		@(posedge link_clk) disable iff (link_rst)
		(state_q == ST_WDATA && scl_fall && byte_full_q && !start_det && !stop_det)
			|=> (ptr_q == $past(ptr_q) + `I2CRS_PTR_STEP && req_vld_q && req_word_q[16]);
	endproperty
	a_wr_inc: assert property (p_wr_inc) else $error("write pointer not advanced");

	property p_master_ack_free;
		@(posedge link_clk) disable iff (link_rst)
		state_q == ST_RDATA_ACK |-> !sda_oe;
	endproperty
	a_master_ack_free: assert property (p_master_ack_free) else $error("line held in ack");

	property p_eight_bits;
		@(posedge link_clk) disable iff (link_rst)
		(state_q == ST_REG && scl_rise && bit_cnt_q == `I2CRS_BIT_LAST && !start_det)
			|=> byte_full_q;
	endproperty
	a_eight_bits: assert property (p_eight_bits) else $error("byte not complete at 8");

	property p_ready;
		@(posedge core_clk) disable iff (rst)
		sample_set_strobe |=> data_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("data ready not raised");

	property p_commit;
		@(posedge core_clk) disable iff (rst)
		core_req_vld && core_req_word[16]
			|=> (reg_wr_en && reg_addr == $past(core_req_word[15:8]));
	endproperty
	a_commit: assert property (p_commit) else $error("write not committed");

endmodule : i2crs_slave

// *** hdl/i2crs_consts.svh ***
/*
 * Constants of the two-wire register access slave: address, field and count values.
 * Assumes it is included by bare name from the slave module only.
 */
`ifndef I2CRS_CONSTS_SVH
`define I2CRS_CONSTS_SVH

// ----------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------
`define I2CRS_ADDR_HIGH  6'h0E
`define I2CRS_DIR_READ   1'h1

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define I2CRS_BIT_FIRST  3'h0
`define I2CRS_BIT_LAST   3'h7
`define I2CRS_PTR_STEP   8'h01
`define I2CRS_PTR_RESET  8'h00
`define I2CRS_BYTE_ZERO  8'h00

// ----------------------------------------------------------------
// Sample set: reading this register clears the data ready output
// ----------------------------------------------------------------
`define I2CRS_SAMPLE_LAST 8'h06

`endif

// *** hdl/i2crs_pkg.sv ***
/*
 * Types of the two-wire register access slave.
 * Assumes the constants header is on the include path.
 */
package i2crs_pkg;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_REG       = 4'b0011,
		ST_REG_ACK   = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_RDATA_ACK = 4'b1000,
		ST_IGNORE    = 4'b1001
	} i2crs_state_t;

endpackage : i2crs_pkg

// *** hdl/i2crs_xfer.sv ***
/*
 * Toggle crossing for one data word between two unrelated clocks.
 * Assumes valid pulses in the source domain are spaced by at least eight
 * destination clocks, so the held word is stable while the toggle crosses.
 */
`timescale 1ns/10ps
module i2crs_xfer #(
	parameter int W = 8
) (
	// Source side
	input  wire logic         src_clk,
	input  wire logic         src_rst,
	input  wire logic         src_valid,
	input  wire logic [W-1:0] src_data,
	// Destination side
	input  wire logic         dst_clk,
	input  wire logic         dst_rst,
	output logic              dst_valid,
	output logic [W-1:0]      dst_data
);

	logic         tgl_q;
	logic [W-1:0] hold_q;
	logic         tgl_m_q;
	logic         tgl_s_q;
	logic         tgl_p_q;

	always_ff @(posedge src_clk) begin
		if (src_rst) begin
			tgl_q  <= 1'b0;
			hold_q <= '0;
		end else if (src_valid) begin
			tgl_q  <= ~tgl_q;
			hold_q <= src_data;
		end
	end

	// First stage is read only by the second
	always_ff @(posedge dst_clk) begin
		if (dst_rst) begin
			tgl_m_q <= 1'b0;
			tgl_s_q <= 1'b0;
			tgl_p_q <= 1'b0;
		end else begin
			tgl_m_q <= tgl_q;
			tgl_s_q <= tgl_m_q;
			tgl_p_q <= tgl_s_q;
		end
	end

	always_ff @(posedge dst_clk) begin
		if (dst_rst) begin
			dst_valid <= 1'b0;
			dst_data  <= '0;
		end else begin
			dst_valid <= tgl_s_q ^ tgl_p_q;
			if (tgl_s_q ^ tgl_p_q) begin
				dst_data <= hold_q;
			end
		end
	end

endmodule : i2crs_xfer

// *** dv/i2crs_mst_model.sv ***
/*
 * Behavioural two-wire bus master driving the serial clock and data lines.
 * Assumes an open-drain wire with pull-up resolved by the bench from sda_low.
 */
`timescale 1ns/10ps
module i2crs_mst_model #(
	parameter real TQ = 625.0
) (
	// Bus lines
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_low
);
	// Quarter bit time; the bench may slow it for a standard rate frame
	real tq = TQ;

	// ----------------------------------------------------------------
	// Idle: clock stands high between frames
	// ----------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ----------------------------------------------------------------
	// Bit and frame primitives, 400 kHz by default
	// ----------------------------------------------------------------
	task automatic bit_io(input logic b, output logic s);
		sda_low = ~b;
		#tq scl = 1'b1;
		#tq s = sda_wire;
		#tq scl = 1'b0;
		#tq;
	endtask : bit_io

	// Works from idle and as a repeated start after an ack slot
	task automatic start();
		sda_low = 1'b0;
		#tq scl = 1'b1;
		#tq sda_low = 1'b1;
		#tq scl = 1'b0;
		#tq;
	endtask : start

	task automatic stop();
		sda_low = 1'b1;
		#tq scl = 1'b1;
		#tq sda_low = 1'b0;
		#tq;
	endtask : stop

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : wr_byte

	task automatic rd_byte(input logic give_ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~give_ack, s);
	endtask : rd_byte
endmodule : i2crs_mst_model

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the two-wire register access slave.
 * Assumes the master model above and a behavioural register file here.
 */
`timescale 1ns/10ps
module tb_top;
	logic        core_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst = 1'b1;
	logic        address_select_pin = 1'b0;
	logic        sample_set_strobe = 1'b0;
	logic [7:0]  reg_rd_data = 8'h00;
	logic        sda_out, sda_oe, reg_wr_en, reg_rd_en, data_ready;
	logic [7:0]  reg_addr, reg_wdata, ra;
	logic        scl, sda_low;
	logic [7:0]  regs [256];
	logic [15:0] exp_wr [$];
	int          failures = 0;
	int          compares = 0;
	// Open drain: the device pulls only while enabled and driving zero
	wire         sda_wire = ~sda_low & (~sda_oe | sda_out);

	initial forever #12.5 core_clk = ~core_clk;
	initial begin
		#3.3;
		forever #6 link_clk = ~link_clk;
	end

	i2crs_slave u_dut (.core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_in(scl),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
		.address_select_pin(address_select_pin), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rd_data(reg_rd_data), .sample_set_strobe(sample_set_strobe),
		.data_ready(data_ready));
	i2crs_mst_model u_mst (.sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));

	// ----------------------------------------------------------------
	// Checking and verdict
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wrap_up();
		if (failures == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Register file: X as expectation flags any write not announced
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (reg_wr_en === 1'b1) begin
			regs[reg_addr] = reg_wdata;
			chk({reg_addr, reg_wdata}, (exp_wr.size() > 0) ? exp_wr.pop_front() : 16'hXXXX);
		end
	end
	always @(negedge core_clk) reg_rd_data <= regs[reg_addr];

	// ----------------------------------------------------------------
	// Frames
	// ----------------------------------------------------------------
	task automatic wr_frame(input logic [6:0] dev, input logic [7:0] ra, input int n,
			input logic hit);
		logic       a;
		logic [7:0] d;
		u_mst.start();
		u_mst.wr_byte({dev, 1'b0}, a);
		chk({15'h0, a}, {15'h0, hit});
		u_mst.wr_byte(ra, a);
		chk({15'h0, a}, {15'h0, hit});
		for (int i = 0; i < n; i++) begin
			d = 8'($urandom);
			if (hit) exp_wr.push_back({8'(ra + i), d});
			u_mst.wr_byte(d, a);
			chk({15'h0, a}, {15'h0, hit});
		end
		u_mst.stop();
		repeat (40) @(negedge core_clk);
		chk(16'(exp_wr.size()), 16'h0000);
	endtask : wr_frame

	task automatic rd_frame(input logic [6:0] dev, input logic [7:0] ra, input int n);
		logic       a;
		logic [7:0] d;
		u_mst.start();
		u_mst.wr_byte({dev, 1'b0}, a);
		u_mst.wr_byte(ra, a);
		chk({15'h0, a}, 16'h0001);
		u_mst.start();
		u_mst.wr_byte({dev, 1'b1}, a);
		chk({15'h0, a}, 16'h0001);
		for (int i = 0; i < n; i++) begin
			u_mst.rd_byte(i < n - 1, d);
			chk({8'h00, d}, {8'h00, regs[8'(ra + i)]});
		end
		u_mst.stop();
		repeat (8) @(negedge core_clk);
	endtask : rd_frame

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hD00E1AA7));
		foreach (regs[i]) regs[i] = 8'($urandom);
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		chk({15'h0, data_ready}, 16'h0000);
		ra = 8'($urandom);
		wr_frame(7'h1C, ra, 3, 1'b1);
		rd_frame(7'h1C, ra, 3);
		rd_frame(7'h1C, 8'hFF, 2);
		address_select_pin = 1'b1;
		repeat (4) @(negedge core_clk);
		wr_frame(7'h1C, ra, 1, 1'b0);
		wr_frame(7'h1E, ra, 1, 1'b0);
		wr_frame(7'h5D, ra, 1, 1'b0);
		// Standard rate frame, quarter bit of 2500 ns
		u_mst.tq = 2500.0;
		wr_frame(7'h1D, ra, 1, 1'b1);
		u_mst.tq = 625.0;
		rd_frame(7'h1D, ra, 1);
		sample_set_strobe = 1'b1;
		@(negedge core_clk);
		sample_set_strobe = 1'b0;
		chk({15'h0, data_ready}, 16'h0001);
		rd_frame(7'h1D, 8'h06, 1);
		chk({15'h0, data_ready}, 16'h0000);
		repeat (2) begin
			ra = 8'($urandom);
			wr_frame(7'h1D, ra, 3, 1'b1);
			rd_frame(7'h1D, ra, 3);
		end
		wrap_up();
	end

	initial begin
		#2_300_000;
		failures++;
		wrap_up();
	end
endmodule : tb_top
